/* File: hdl/gfm_params.svh */
// Register offsets, field positions and reset values of the pin function mux.
`ifndef GFM_PARAMS_SVH
`define GFM_PARAMS_SVH
`define GFM_ADDR_PIN_OUT_EN 4'h0
`define GFM_ADDR_PIN_LEVEL 4'h1
`define GFM_ADDR_PIN_MODE 4'h2
`define GFM_ADDR_DAC_CTRL 4'h3
`define GFM_ADDR_AMP1_CTRL 4'h4
`define GFM_ADDR_AMP2_CTRL 4'h5
`define GFM_ADDR_AUX2_CTRL 4'h6
`define GFM_ADDR_SYS_CTRL 4'h7
`define GFM_ADDR_PIN_INPUT 4'h8
`define GFM_ADDR_CONV_CHAN 4'h9
`define GFM_ADDR_ROUTE 4'hA
`define GFM_DAC_EN_BIT 0
`define GFM_DAC_DIGIN_BIT 1
`define GFM_AMP_NONINV_BIT 0
`define GFM_AMP_INV_BIT 1
`define GFM_AMP_EN_BIT 2
`define GFM_AUX2_EN_BIT 0
`define GFM_AUX2_SYS_BIT 1
`define GFM_ID_READ_BIT 0
`define GFM_CONV_START_BIT 8
`define GFM_MODE_W 3
`define GFM_NPINS 5
`define GFM_CHAN_W 5
`define GFM_RESET_ZERO 32'h00000000
`endif

/* File: hdl/gfm_pin_mux.sv */
// Function selection, overrides and readback for general purpose pins 8 to 12.
`timescale 1ns/100ps
`include "gfm_params.svh"
//
// Contract
// - DAC enable forces pin 8 output enable low and connects the DAC.
// - DAC enable bit lives in the DAC control register, switches pin 8.
// - Pin 8 level reads back only while its digital input enable is set.
// - Amp1 non-inverting connect makes pin 9 an amp input, no drive.
// - Pin 9 mode picks level, interrupt, pulse 2, loop 3 or inverses.
// - Pin 9 output feeds bridge external pulse input 1.
// - Pins 9 and 10 are taken by the system during identification read.
// - Amp1 inverting connect makes pin 10 an amp input, no drive.
// - Pin 10 mode picks level, interrupt, pulse 2, pulse 3 or inverses.
// - Pin 10 output feeds bridge external pulse input 2.
// - Amp1 enable puts amp1 output on pin 11, digital drive off.
// - Pin 11 mode picks level, converter out, pulse 1, pulse 2, inverses.
// - Pin 11 output feeds bridge external pulse input 4.
// - Aux regulator 2 enable or system role puts loop 2 on pin 12.
// - Amp2 non-inverting connect makes pin 12 an amp input if no loop.
// - Pin 12 mode picks level, interrupt, comparator 2, loop 2, inverses.
// - Pin 12 output feeds the stepper step command input.
// - Each pin stays selectable as converter input via channel field.
// - Pins 9 to 12 levels are always readable, even while driving; pin 8 needs its digital input enable.
module gfm_pin_mux
    import gfm_pkg::*;
#(
    parameter int NPINS = `GFM_NPINS
)
(
    // Clock and reset.
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    // Avalon-MM slave.
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    // Internal sources.
    input wire logic INTERRUPT_I,
    input wire logic AUX_PULSE_GEN_1_I,
    input wire logic AUX_PULSE_GEN_2_I,
    input wire logic AUX_PULSE_GEN_3_I,
    input wire logic COMPARATOR2_OUTPUT_I,
    input wire logic CONVERTER_GENERAL_OUTPUT_I,
    input wire logic REGULATOR_LOOP2_OUTPUT_I,
    input wire logic REGULATOR_LOOP3_OUTPUT_I,
    input wire logic [1:0] ID_READ_DRIVE_I,
    input wire logic [1:0] ID_READ_OE_I,
    // Pins 8 to 12.
    input wire logic [NPINS-1:0] PIN_I,
    output logic [NPINS-1:0] PIN_O,
    output logic [NPINS-1:0] PIN_OE_O,
    // Analog switch controls.
    output logic CURRENT_SINK_DAC_FUNCTION_O,
    output logic AMP1_NONINV_PIN_O,
    output logic AMP1_INV_PIN_O,
    output logic AMP1_OUT_PIN_O,
    output logic AMP2_NONINV_PIN_O,
    output logic REG_LOOP2_PIN_O,
    // Internal routes and converter request.
    output logic BRIDGE_EXTERNAL_PULSE_IN_1_O,
    output logic BRIDGE_EXTERNAL_PULSE_IN_2_O,
    output logic BRIDGE_EXTERNAL_PULSE_IN_4_O,
    output logic STEPPER_STEP_COMMAND_O,
    output logic [4:0] CONVERTER_CHANNEL_SELECT_O,
    output logic CONVERTER_START_O
);

    //--------------------------------------------------------------
    // Functions
    //--------------------------------------------------------------

    // Apply one pin's mode table; code 4 inverts the code 0 source on pin 11.
    function automatic logic sel_src(input gfm_mode_t m,
                                     input logic lvl,
                                     input logic s1,
                                     input logic s2,
                                     input logic s3,
                                     input logic inv0,
                                     input logic inv_gap);
        logic r;
        r = 1'b0;
        case (m)
            GFM_M_LEVEL: r = lvl;
            GFM_M_SRC1: r = s1;
            GFM_M_SRC2: r = s2;
            GFM_M_SRC3: r = s3;
            GFM_M_INV0: r = inv0 ? ~lvl : ~s1;
            GFM_M_INV1: r = inv0 ? ~s1 : ~s2;
            GFM_M_GAP: r = inv_gap ? ~s2 : 1'b0;
            GFM_M_INV3: r = ~s3;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : sel_src

    // Merge a write into a register under the byte enables.
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : be_merge

    //--------------------------------------------------------------
    // Registers
    //--------------------------------------------------------------

    logic [31:0] out_en_reg;
    logic [31:0] level_reg;
    logic [31:0] mode_reg;
    logic [31:0] dac_ctrl_reg;
    logic [31:0] amp1_ctrl_reg;
    logic [31:0] amp2_ctrl_reg;
    logic [31:0] aux2_ctrl_reg;
    logic [31:0] sys_ctrl_reg;
    logic [31:0] conv_chan_reg;
    logic conv_start_reg;
    logic [31:0] rdata_reg;
    logic rvalid_reg;
    logic [NPINS-1:0] pin_sync1_reg;
    logic [NPINS-1:0] pin_sync2_reg;
    logic [NPINS-1:0] pin_drv_reg;
    logic [NPINS-1:0] pin_oe_reg;
    logic [3:0] route_reg;
    logic [5:0] sw_reg;

    wire wr_hit = AVS_WRITE_I;
    wire rd_hit = AVS_READ_I & ~rvalid_reg;
    // Writes finish in one cycle, reads take one wait state.
    assign AVS_WAITREQUEST_O = AVS_READ_I & ~rvalid_reg;

    //--------------------------------------------------------------
    // Override decode
    //--------------------------------------------------------------

    wire dac_en = dac_ctrl_reg[`GFM_DAC_EN_BIT];
    wire dac_digin = dac_ctrl_reg[`GFM_DAC_DIGIN_BIT];
    wire amp1_noninv_input_connect = amp1_ctrl_reg[`GFM_AMP_NONINV_BIT];
    wire amp1_inv_input_connect = amp1_ctrl_reg[`GFM_AMP_INV_BIT];
    wire amp1_enable = amp1_ctrl_reg[`GFM_AMP_EN_BIT];
    wire amp2_noninv_input_connect = amp2_ctrl_reg[`GFM_AMP_NONINV_BIT];
    wire aux2_on = aux2_ctrl_reg[`GFM_AUX2_EN_BIT]
                 | aux2_ctrl_reg[`GFM_AUX2_SYS_BIT];
    wire id_read = sys_ctrl_reg[`GFM_ID_READ_BIT];
    wire [2:0] m8 = mode_reg[2:0];
    wire [2:0] m9 = mode_reg[6:4];
    wire [2:0] m10 = mode_reg[10:8];
    wire [2:0] m11 = mode_reg[14:12];
    wire [2:0] m12 = mode_reg[18:16];

    // Pin 8 keeps its own table from the neighbouring pin family.
    wire src8 = sel_src(m8, level_reg[0], AUX_PULSE_GEN_1_I,
                        AUX_PULSE_GEN_3_I, COMPARATOR2_OUTPUT_I,
                        1'b0, 1'b0);
    wire src9 = sel_src(m9, level_reg[1], INTERRUPT_I,
                        AUX_PULSE_GEN_2_I, REGULATOR_LOOP3_OUTPUT_I,
                        1'b0, 1'b0);
    wire src10 = sel_src(m10, level_reg[2], INTERRUPT_I,
                         AUX_PULSE_GEN_2_I, AUX_PULSE_GEN_3_I,
                         1'b0, 1'b0);
    wire src11 = sel_src(m11, level_reg[3], CONVERTER_GENERAL_OUTPUT_I,
                         AUX_PULSE_GEN_1_I, AUX_PULSE_GEN_2_I,
                         1'b1, 1'b1);
    wire src12 = sel_src(m12, level_reg[4], INTERRUPT_I,
                         COMPARATOR2_OUTPUT_I, REGULATOR_LOOP2_OUTPUT_I,
                         1'b0, 1'b0);

    wire oe8 = out_en_reg[0] & ~dac_en;
    wire oe9 = out_en_reg[1] & ~amp1_noninv_input_connect;
    wire oe10 = out_en_reg[2] & ~amp1_inv_input_connect;
    wire oe11 = out_en_reg[3] & ~amp1_enable;
    wire oe12 = out_en_reg[4] & ~amp2_noninv_input_connect
              & ~aux2_on;

    wire [NPINS-1:0] drv_next;
    wire [NPINS-1:0] oe_next;
    assign drv_next[0] = src8;
    assign oe_next[0] = oe8;
    // The system owns pins 9 and 10 during an identification read.
    assign drv_next[1] = id_read ? ID_READ_DRIVE_I[0] : src9;
    assign oe_next[1] = id_read ? ID_READ_OE_I[0] : oe9;
    assign drv_next[2] = id_read ? ID_READ_DRIVE_I[1] : src10;
    assign oe_next[2] = id_read ? ID_READ_OE_I[1] : oe10;
    assign drv_next[3] = src11;
    assign oe_next[3] = oe11;
    // Loop 2 has the pin whatever the other bits hold.
    assign drv_next[4] = aux2_on ? REGULATOR_LOOP2_OUTPUT_I
                                 : src12;
    assign oe_next[4] = aux2_on | oe12;

    // Internal routes follow the level that each pin drives.
    wire [3:0] route_next = {drv_next[4], drv_next[3], drv_next[2],
                             drv_next[1]};

    //--------------------------------------------------------------
    // Analog switch controls
    //--------------------------------------------------------------

    // The switches move on the same edge as the pin enables, so an analog
    // path meets a driven pin only on pins 9 and 10 during an identification read, and on pin 12 while loop 2 holds it.
    wire [5:0] sw_next;
    assign sw_next[0] = dac_en;
    assign sw_next[1] = amp1_noninv_input_connect;
    assign sw_next[2] = amp1_inv_input_connect;
    assign sw_next[3] = amp1_enable;
    assign sw_next[4] = amp2_noninv_input_connect & ~aux2_on;
    assign sw_next[5] = aux2_on;

    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            sw_reg <= '0;
        end
        else
        begin
            sw_reg <= sw_next;
        end
    end

    //--------------------------------------------------------------
    // Readback
    //--------------------------------------------------------------

    wire [NPINS-1:0] pin_seen;
    assign pin_seen[0] = pin_sync2_reg[0] & dac_digin;
    assign pin_seen[NPINS-1:1] = pin_sync2_reg[NPINS-1:1];

    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = `GFM_RESET_ZERO;
        case (AVS_ADDRESS_I)
            `GFM_ADDR_PIN_OUT_EN: rd_mux = out_en_reg;
            `GFM_ADDR_PIN_LEVEL: rd_mux = level_reg;
            `GFM_ADDR_PIN_MODE: rd_mux = mode_reg;
            `GFM_ADDR_DAC_CTRL: rd_mux = dac_ctrl_reg;
            `GFM_ADDR_AMP1_CTRL: rd_mux = amp1_ctrl_reg;
            `GFM_ADDR_AMP2_CTRL: rd_mux = amp2_ctrl_reg;
            `GFM_ADDR_AUX2_CTRL: rd_mux = aux2_ctrl_reg;
            `GFM_ADDR_SYS_CTRL: rd_mux = sys_ctrl_reg;
            `GFM_ADDR_PIN_INPUT: rd_mux = {27'h0000000, pin_seen};
            `GFM_ADDR_CONV_CHAN: rd_mux = conv_chan_reg;
            `GFM_ADDR_ROUTE: rd_mux = {28'h0000000, route_reg};
            default: rd_mux = `GFM_RESET_ZERO;
        endcase
    end

    //--------------------------------------------------------------
    // Register writes
    //--------------------------------------------------------------

    function automatic logic [31:0] wr(input logic [31:0] old,
                                       input logic [3:0] a,
                                       input logic [31:0] mask,
                                       input logic hit,
                                       input logic [3:0] sel,
                                       input logic [31:0] wd,
                                       input logic [3:0] be);
        logic [31:0] r;
        r = old;
        if (hit && a == sel)
        begin
            r = be_merge(old, wd, be) & mask;
        end
        return r;
    endfunction : wr

    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            out_en_reg <= `GFM_RESET_ZERO;
            level_reg <= `GFM_RESET_ZERO;
            mode_reg <= `GFM_RESET_ZERO;
            dac_ctrl_reg <= `GFM_RESET_ZERO;
            amp1_ctrl_reg <= `GFM_RESET_ZERO;
            amp2_ctrl_reg <= `GFM_RESET_ZERO;
            aux2_ctrl_reg <= `GFM_RESET_ZERO;
            sys_ctrl_reg <= `GFM_RESET_ZERO;
            conv_chan_reg <= `GFM_RESET_ZERO;
            conv_start_reg <= 1'b0;
        end
        else
        begin
            out_en_reg <= wr(out_en_reg, AVS_ADDRESS_I, 32'h0000001F, wr_hit,
                `GFM_ADDR_PIN_OUT_EN, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
            level_reg <= wr(level_reg, AVS_ADDRESS_I, 32'h0000001F, wr_hit,
                `GFM_ADDR_PIN_LEVEL, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
            mode_reg <= wr(mode_reg, AVS_ADDRESS_I, 32'h00077777, wr_hit,
                `GFM_ADDR_PIN_MODE, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
            dac_ctrl_reg <= wr(dac_ctrl_reg, AVS_ADDRESS_I, 32'h00000003,
                wr_hit, `GFM_ADDR_DAC_CTRL, AVS_WRITEDATA_I,
                AVS_BYTEENABLE_I);
            amp1_ctrl_reg <= wr(amp1_ctrl_reg, AVS_ADDRESS_I, 32'h00000007,
                wr_hit, `GFM_ADDR_AMP1_CTRL, AVS_WRITEDATA_I,
                AVS_BYTEENABLE_I);
            amp2_ctrl_reg <= wr(amp2_ctrl_reg, AVS_ADDRESS_I, 32'h00000001,
                wr_hit, `GFM_ADDR_AMP2_CTRL, AVS_WRITEDATA_I,
                AVS_BYTEENABLE_I);
            aux2_ctrl_reg <= wr(aux2_ctrl_reg, AVS_ADDRESS_I, 32'h00000003,
                wr_hit, `GFM_ADDR_AUX2_CTRL, AVS_WRITEDATA_I,
                AVS_BYTEENABLE_I);
            sys_ctrl_reg <= wr(sys_ctrl_reg, AVS_ADDRESS_I, 32'h00000001,
                wr_hit, `GFM_ADDR_SYS_CTRL, AVS_WRITEDATA_I,
                AVS_BYTEENABLE_I);
            conv_chan_reg <= wr(conv_chan_reg, AVS_ADDRESS_I, 32'h0000001F,
                wr_hit, `GFM_ADDR_CONV_CHAN, AVS_WRITEDATA_I,
                AVS_BYTEENABLE_I);
            // Start pulses for one cycle when bit 8 is written as one.
            conv_start_reg <= wr_hit
                & (AVS_ADDRESS_I == `GFM_ADDR_CONV_CHAN)
                & AVS_BYTEENABLE_I[1]
                & AVS_WRITEDATA_I[`GFM_CONV_START_BIT];
        end
    end

    //--------------------------------------------------------------
    // Pins, read data and routes
    //--------------------------------------------------------------

    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            pin_sync1_reg <= '0;
            pin_sync2_reg <= '0;
            pin_drv_reg <= '0;
            pin_oe_reg <= '0;
            route_reg <= 4'h0;
            rdata_reg <= `GFM_RESET_ZERO;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            pin_sync1_reg <= PIN_I;
            pin_sync2_reg <= pin_sync1_reg;
            pin_drv_reg <= drv_next;
            pin_oe_reg <= oe_next;
            route_reg <= route_next;
            rvalid_reg <= rd_hit;
            rdata_reg <= rd_hit ? rd_mux : rdata_reg;
        end
    end

    assign AVS_READDATA_O = rdata_reg;
    assign PIN_O = pin_drv_reg;
    assign PIN_OE_O = pin_oe_reg;
    assign BRIDGE_EXTERNAL_PULSE_IN_1_O = route_reg[0];
    assign BRIDGE_EXTERNAL_PULSE_IN_2_O = route_reg[1];
    assign BRIDGE_EXTERNAL_PULSE_IN_4_O = route_reg[2];
    assign STEPPER_STEP_COMMAND_O = route_reg[3];
    assign CURRENT_SINK_DAC_FUNCTION_O = sw_reg[0];
    assign AMP1_NONINV_PIN_O = sw_reg[1];
    assign AMP1_INV_PIN_O = sw_reg[2];
    assign AMP1_OUT_PIN_O = sw_reg[3];
    assign AMP2_NONINV_PIN_O = sw_reg[4];
    assign REG_LOOP2_PIN_O = sw_reg[5];
    assign CONVERTER_CHANNEL_SELECT_O = conv_chan_reg[4:0];
    assign CONVERTER_START_O = conv_start_reg;

endmodule : gfm_pin_mux

/* File: hdl/gfm_pkg.sv */
// Types shared by the pin function mux.
package gfm_pkg;
    typedef logic [2:0] gfm_mode_t;
    typedef enum logic [2:0]
    {
        GFM_M_LEVEL = 3'h0,
        GFM_M_SRC1 = 3'h1,
        GFM_M_SRC2 = 3'h2,
        GFM_M_SRC3 = 3'h3,
        GFM_M_INV0 = 3'h4,
        GFM_M_INV1 = 3'h5,
        GFM_M_GAP = 3'h6,
        GFM_M_INV3 = 3'h7
    } gfm_mode_e;
endpackage : gfm_pkg

/* File: test/gfm_pin_mux_checker.sv */
// Concurrent checks on the ports of the pin function mux.
`timescale 1ns/100ps
module gfm_pin_mux_checker
#(
    parameter int NPINS = 5
)
(
    // Clock, reset and bus.
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic AVS_WAITREQUEST_O,
    // Pins, switches and routes.
    input wire logic [NPINS-1:0] PIN_O,
    input wire logic [NPINS-1:0] PIN_OE_O,
    input wire logic CURRENT_SINK_DAC_FUNCTION_O,
    input wire logic AMP1_NONINV_PIN_O,
    input wire logic AMP2_NONINV_PIN_O,
    input wire logic REG_LOOP2_PIN_O,
    input wire logic BRIDGE_EXTERNAL_PULSE_IN_1_O,
    input wire logic STEPPER_STEP_COMMAND_O,
    input wire logic CONVERTER_START_O
);
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RESETN_I);
    // A write to the channel word with the start bit set.
    wire logic start_req = AVS_WRITE_I && AVS_ADDRESS_I == 4'h9
        && AVS_WRITEDATA_I[8] && AVS_BYTEENABLE_I[1];

    property p_wr; AVS_WRITE_I |-> !AVS_WAITREQUEST_O; endproperty
    a_wr: assert property (p_wr) else $error("write was stalled");
    property p_rd;
        AVS_READ_I && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O;
    endproperty
    a_rd: assert property (p_rd) else $error("read waited twice");
    property p_unmap;
        AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I > 4'hA
            |-> AVS_READDATA_O == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not 0");
    property p_dac; CURRENT_SINK_DAC_FUNCTION_O |-> !PIN_OE_O[0];
    endproperty
    a_dac: assert property (p_dac) else $error("pin 8 driven");
    property p_amp1;
        $past(AMP1_NONINV_PIN_O) && AMP1_NONINV_PIN_O |-> !PIN_OE_O[1];
    endproperty
    a_amp1: assert property (p_amp1) else $error("pin 9 driven");
    property p_amp2;
        AMP2_NONINV_PIN_O |-> !PIN_OE_O[4];
    endproperty
    a_amp2: assert property (p_amp2) else $error("pin 12 on");
    property p_loop2;
        REG_LOOP2_PIN_O |-> !AMP2_NONINV_PIN_O && PIN_OE_O[NPINS-1];
    endproperty
    a_loop2: assert property (p_loop2) else $error("loop 2 lost");
    property p_ext1;
        PIN_O == $past(PIN_O) |-> BRIDGE_EXTERNAL_PULSE_IN_1_O == PIN_O[1];
    endproperty
    a_ext1: assert property (p_ext1) else $error("route 1 off");
    property p_step;
        $stable(PIN_O) |-> STEPPER_STEP_COMMAND_O == PIN_O[NPINS-1];
    endproperty
    a_step: assert property (p_step) else $error("step off");
    property p_start; CONVERTER_START_O == $past(start_req); endproperty
    a_start: assert property (p_start) else $error("bad start");
endmodule : gfm_pin_mux_checker

bind gfm_pin_mux gfm_pin_mux_checker #(.NPINS(NPINS)) u_gfm_chk
(
    .MCLK_I(MCLK_I), .RESETN_I(RESETN_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
    .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .PIN_O(PIN_O), .PIN_OE_O(PIN_OE_O),
    .CURRENT_SINK_DAC_FUNCTION_O(CURRENT_SINK_DAC_FUNCTION_O),
    .AMP1_NONINV_PIN_O(AMP1_NONINV_PIN_O),
    .AMP2_NONINV_PIN_O(AMP2_NONINV_PIN_O), .REG_LOOP2_PIN_O(REG_LOOP2_PIN_O),
    .BRIDGE_EXTERNAL_PULSE_IN_1_O(BRIDGE_EXTERNAL_PULSE_IN_1_O),
    .STEPPER_STEP_COMMAND_O(STEPPER_STEP_COMMAND_O),
    .CONVERTER_START_O(CONVERTER_START_O)
);

/* File: test/gfm_pin_mux_tb.sv */
// Self-checking bench for the pin function mux of pins 8 to 12.
`timescale 1ns/100ps
module gfm_pin_mux_tb;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] be = 4'hF;
    logic [31:0] wdat = 32'h0;
    logic [7:0] src = 8'h00;
    logic [1:0] id_drv = 2'h0;
    logic [1:0] id_oe = 2'h0;
    logic [4:0] board = 5'h00;
    logic [31:0] rdw;
    logic [4:0] pin_in, pin_o, pin_oe, exp, chan;
    logic wq, dac, a1n, a1i, a1o, a2n, rl2, ext1, ext2, ext4, step, start;
    int errors = 0;
    int check_count = 0;
    int starts = 0;
    int cycles = 0;

    always #25 mclk = ~mclk;

    gfm_pin_mux DUT
    (
        .MCLK_I(mclk), .RESETN_I(resetn), .AVS_ADDRESS_I(adr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat),
        .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdw), .AVS_WAITREQUEST_O(wq),
        .INTERRUPT_I(src[0]), .AUX_PULSE_GEN_1_I(src[1]),
        .AUX_PULSE_GEN_2_I(src[2]), .AUX_PULSE_GEN_3_I(src[3]),
        .COMPARATOR2_OUTPUT_I(src[4]), .CONVERTER_GENERAL_OUTPUT_I(src[5]),
        .REGULATOR_LOOP2_OUTPUT_I(src[6]), .REGULATOR_LOOP3_OUTPUT_I(src[7]),
        .ID_READ_DRIVE_I(id_drv), .ID_READ_OE_I(id_oe), .PIN_I(pin_in),
        .PIN_O(pin_o), .PIN_OE_O(pin_oe), .CURRENT_SINK_DAC_FUNCTION_O(dac),
        .AMP1_NONINV_PIN_O(a1n), .AMP1_INV_PIN_O(a1i), .AMP1_OUT_PIN_O(a1o),
        .AMP2_NONINV_PIN_O(a2n), .REG_LOOP2_PIN_O(rl2),
        .BRIDGE_EXTERNAL_PULSE_IN_1_O(ext1),
        .BRIDGE_EXTERNAL_PULSE_IN_2_O(ext2),
        .BRIDGE_EXTERNAL_PULSE_IN_4_O(ext4), .STEPPER_STEP_COMMAND_O(step),
        .CONVERTER_CHANNEL_SELECT_O(chan), .CONVERTER_START_O(start)
    );
    gfm_pin_world u_world
    (
        .pin_o_i(pin_o), .pin_oe_i(pin_oe), .board_level_i(board),
        .wire_o(pin_in)
    );

    always @(posedge mclk)
    begin
        cycles++;
        if (start === 1'b1)
            starts++;
        if (cycles == 20000)
        begin
            errors++;
            complete_run();
        end
    end

    // Pin levels for one mode code; s holds int, pulse 1 to 3, comp 2,
    // converter output, loop 2 and loop 3 from bit 0 up.
    function automatic logic [4:0] exp_pins(input logic [2:0] c,
        input logic [4:0] l, input logic [7:0] s);
        logic [7:0] t8, t9, t10, t11, t12;
        t8 = {~s[4], 1'b0, ~s[3], ~s[1], s[4], s[3], s[1], l[0]};
        t9 = {~s[7], 1'b0, ~s[2], ~s[0], s[7], s[2], s[0], l[1]};
        t10 = {~s[3], 1'b0, ~s[2], ~s[0], s[3], s[2], s[0], l[2]};
        t11 = {~s[2], ~s[1], ~s[5], ~l[3], s[2], s[1], s[5], l[3]};
        t12 = {~s[6], 1'b0, ~s[4], ~s[0], s[6], s[4], s[0], l[4]};
        return {t12[c], t11[c], t10[c], t9[c], t8[c]};
    endfunction : exp_pins

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want)
        begin
            errors++;
            $display("MISMATCH at %0t: got %h, expected %h", $time, seen, want);
        end
    endtask : check

    task automatic av_write(input logic [3:0] a, input logic [31:0] d);
        adr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge mclk);
        while (wq !== 1'b0)
            @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask : av_write

    task automatic rd_check(input logic [3:0] a, input logic [31:0] want);
        adr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        while (wq !== 1'b0)
            @(posedge mclk);
        check(rdw, want);
        rd <= 1'b0;
        @(posedge mclk);
    endtask : rd_check

    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    initial
    begin
        logic [2:0] m;
        logic [4:0] lvl;
        logic [7:0] s;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        for (int a = 0; a < 16; a++)
            rd_check(4'(a), 32'h0);
        be <= 4'h0;
        av_write(4'h0, 32'h1F);
        rd_check(4'h0, 32'h0);
        be <= 4'hF;
        av_write(4'h0, 32'h1F);
        $display("Test reset and refusals done");
        for (int c = 0; c < 8; c++)
            for (int p = 0; p < 2; p++)
            begin
                m = 3'(c);
                lvl = p ? 5'h0A : 5'h15;
                s = p ? 8'h5A : 8'hA5;
                src <= s;
                av_write(4'h1, {27'h0, lvl});
                av_write(4'h2, {13'h0, m, 1'b0, m, 1'b0, m, 1'b0, m, 1'b0, m});
                repeat (4) @(posedge mclk);
                exp = exp_pins(m, lvl, s);
                check({27'h0, pin_o}, {27'h0, exp});
                check({27'h0, pin_oe}, 32'h1F);
                check({28'h0, step, ext4, ext2, ext1}, {28'h0, exp[4:1]});
                rd_check(4'hA, {28'h0, exp[4:1]});
                rd_check(4'h8, {27'h0, exp[4:1], 1'b0});
            end
        $display("Test mode tables done");
        av_write(4'h9, 32'h10D);
        repeat (2) @(posedge mclk);
        check({27'h0, chan}, 32'h0D);
        be <= 4'h1;
        av_write(4'h9, 32'h116);
        be <= 4'hF;
        repeat (2) @(posedge mclk);
        check({27'h0, chan}, 32'h16);
        av_write(4'h9, 32'h003);
        repeat (2) @(posedge mclk);
        check({27'h0, chan}, 32'h03);
        check(32'(starts), 32'h1);
        $display("Test converter select done");
        av_write(4'h3, 32'h1);
        av_write(4'h4, 32'h7);
        av_write(4'h5, 32'h1);
        repeat (3) @(posedge mclk);
        check({27'h0, pin_oe}, 32'h0);
        check({26'h0, dac, a1n, a1i, a1o, a2n, rl2}, 32'h3E);
        av_write(4'h6, 32'h2);
        repeat (2) @(posedge mclk);
        check({30'h0, a2n, rl2}, 32'h1);
        check({30'h0, pin_oe[4], pin_o[4]}, {30'h0, 1'b1, src[6]});
        av_write(4'h6, 32'h0);
        av_write(4'h0, 32'h0);
        av_write(4'h3, 32'h0);
        board <= 5'h0B;
        repeat (4) @(posedge mclk);
        rd_check(4'h8, 32'h0A);
        av_write(4'h3, 32'h2);
        rd_check(4'h8, 32'h0B);
        $display("Test overrides done");
        av_write(4'h4, 32'h0);
        av_write(4'h5, 32'h0);
        av_write(4'h0, 32'h1F);
        id_drv <= 2'h1;
        id_oe <= 2'h3;
        av_write(4'h7, 32'h1);
        repeat (3) @(posedge mclk);
        check({30'h0, pin_o[2:1]}, 32'h1);
        check({30'h0, pin_oe[2:1]}, 32'h3);
        $display("Test identification read done");
        complete_run();
    end
endmodule : gfm_pin_mux_tb

/* File: test/gfm_pin_world.sv */
// Model of the board wiring on pins 8 to 12.
`timescale 1ns/100ps
module gfm_pin_world
(
    // Drive from the mux and the level the board puts on free pins.
    input wire logic [4:0] pin_o_i,
    input wire logic [4:0] pin_oe_i,
    input wire logic [4:0] board_level_i,
    // Resolved wire level.
    output logic [4:0] wire_o
);
    // A driven pin reads back its own level, a free one the board level.
    assign wire_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & board_level_i);
endmodule : gfm_pin_world
